/* File: common/arcc_pkg.sv */
package arcc_pkg;

  // Byte addresses on the APB; the first three are the fixed map
  localparam logic [31:0] ARCC_OFF_AUX_GAIN = 32'hFFFF0530;
  localparam logic [31:0] ARCC_OFF_LIMIT    = 32'hFFFF0534;
  localparam logic [31:0] ARCC_OFF_COUNT    = 32'hFFFF0538;
  localparam logic [31:0] ARCC_OFF_MODE     = 32'hFFFF0600;
  localparam logic [31:0] ARCC_OFF_CONFIG   = 32'hFFFF0604;
  localparam logic [31:0] ARCC_OFF_PCTRL    = 32'hFFFF0608;

  // Reset values
  localparam logic [15:0] ARCC_RST_LIMIT  = 16'h0001;
  localparam logic [15:0] ARCC_RST_COUNT  = 16'h0000;
  localparam logic [15:0] ARCC_RST_GAIN   = 16'h0000;
  localparam logic [2:0]  ARCC_RST_MODE   = 3'h0;
  localparam logic [7:0]  ARCC_RST_CONFIG = 8'h00;
  localparam logic [15:0] ARCC_RST_PCTRL  = 16'h0000;

  // Mode field codes and config bit position
  localparam logic [2:0]  ARCC_MODE_IDLE     = 3'h3;
  localparam logic [2:0]  ARCC_MODE_AUX_GCAL = 3'h6;
  localparam int          ARCC_CFG_CNT_EN    = 0;

  // Events from the conversion engine, same clock
  typedef struct packed {
    logic        conv_done;
    logic        gcal_done;
    logic [15:0] gcal_value;
  } arcc_evt_t;

endpackage

/* File: verilog/arcc_regs.sv */
// How it works
// - A 16-bit auxiliary gain coefficient register scales auxiliary results.
// - At power-on the gain loads the factory value, not a constant.
// - Auxiliary gain calibration overwrites the gain with the new value.
// - Software gain writes take effect only in idle mode.
// - 16-bit read-write count limit, resets to 0x0001.
// - 16-bit read-only result count, resets to zero, counts conversions.
// - When count reaches the limit it returns to zero and continues.
// - With counting enabled, interrupt fires only when the limit is reached.
// - Writes to primary control or mode registers clear the count.
// - Count stays readable beside the accumulator for averaging.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module arcc_regs
  import arcc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire arcc_evt_t   engine_evt,
  input  wire logic [15:0] factory_gain,
  output logic      [15:0] aux_gain,
  output logic      [2:0]  adc_mode,
  output logic      [15:0] primary_ctrl,
  output logic             count_en,
  output logic             adc_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state; read data is registered in the setup phase so it comes from a flop

  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        wr_en;
  logic        addr_hit;
  logic [15:0] gain_r;
  logic [15:0] gain_nxt;
  logic        loaded_r;
  logic        loaded_nxt;
  logic [15:0] limit_r;
  logic [15:0] limit_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] cnt_inc;
  logic [2:0]  mode_r;
  logic [2:0]  mode_nxt;
  logic [7:0]  cfg_r;
  logic [7:0]  cfg_nxt;
  logic [15:0] pctrl_r;
  logic [15:0] pctrl_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        gain_wr;
  logic        clr_wr;
  logic        cnt_on;

  assign wr_en   = psel & penable & pready_r & pwrite;
  assign gain_wr = wr_en & (paddr == ARCC_OFF_AUX_GAIN);
  assign clr_wr  = wr_en & ((paddr == ARCC_OFF_MODE) |
                            (paddr == ARCC_OFF_PCTRL));
  assign cnt_on  = cfg_r[ARCC_CFG_CNT_EN];
  assign cnt_inc = cnt_r + 16'h0001;

  assign addr_hit = (paddr == ARCC_OFF_AUX_GAIN) |
                    (paddr == ARCC_OFF_LIMIT)    |
                    (paddr == ARCC_OFF_COUNT)    |
                    (paddr == ARCC_OFF_MODE)     |
                    (paddr == ARCC_OFF_CONFIG)   |
                    (paddr == ARCC_OFF_PCTRL);

  always_comb begin
    pready_nxt  = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~addr_hit;
    prdata_nxt  = 32'h00000000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ARCC_OFF_AUX_GAIN: prdata_nxt = {16'h0000, gain_r};
        ARCC_OFF_LIMIT:    prdata_nxt = {16'h0000, limit_r};
        ARCC_OFF_COUNT:    prdata_nxt = {16'h0000, cnt_r};
        ARCC_OFF_MODE:     prdata_nxt = {29'h0, mode_r};
        ARCC_OFF_CONFIG:   prdata_nxt = {24'h000000, cfg_r};
        ARCC_OFF_PCTRL:    prdata_nxt = {16'h0000, pctrl_r};
        default:           prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain coefficient and configuration registers

  // Factory value is taken at the first edge after reset release, since an
  // async reset may only load a constant
  always_comb begin
    gain_nxt   = gain_r;
    loaded_nxt = 1'b1;
    limit_nxt  = limit_r;
    mode_nxt   = mode_r;
    cfg_nxt    = cfg_r;
    pctrl_nxt  = pctrl_r;
    if (!loaded_r) begin
      gain_nxt = factory_gain;
    end else if (engine_evt.gcal_done && mode_r == ARCC_MODE_AUX_GCAL) begin
      gain_nxt = engine_evt.gcal_value;
    end else if (gain_wr && mode_r == ARCC_MODE_IDLE) begin
      gain_nxt = pwdata[15:0];
    end
    if (wr_en && paddr == ARCC_OFF_LIMIT) begin
      limit_nxt = pwdata[15:0];
    end
    if (wr_en && paddr == ARCC_OFF_MODE) begin
      mode_nxt = pwdata[2:0];
    end
    if (wr_en && paddr == ARCC_OFF_CONFIG) begin
      cfg_nxt = pwdata[7:0];
    end
    if (wr_en && paddr == ARCC_OFF_PCTRL) begin
      pctrl_nxt = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_r   <= ARCC_RST_GAIN;
      loaded_r <= 1'b0;
      limit_r  <= ARCC_RST_LIMIT;
      mode_r   <= ARCC_RST_MODE;
      cfg_r    <= ARCC_RST_CONFIG;
      pctrl_r  <= ARCC_RST_PCTRL;
    end else begin
      gain_r   <= gain_nxt;
      loaded_r <= loaded_nxt;
      limit_r  <= limit_nxt;
      mode_r   <= mode_nxt;
      cfg_r    <= cfg_nxt;
      pctrl_r  <= pctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result counter and interrupt divider

  // A reconfiguring write wins over a conversion in the same cycle; the
  // interrupt for that conversion is still raised
  always_comb begin
    cnt_nxt = cnt_r;
    irq_nxt = 1'b0;
    if (engine_evt.conv_done) begin
      if (cnt_on) begin
        if (cnt_inc == limit_r) begin
          cnt_nxt = 16'h0000;
          irq_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_inc;
        end
      end else begin
        irq_nxt = 1'b1;
      end
    end
    if (clr_wr) begin
      cnt_nxt = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= ARCC_RST_COUNT;
      irq_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign aux_gain     = gain_r;
  assign adc_mode     = mode_r;
  assign primary_ctrl = pctrl_r;
  assign count_en     = cfg_r[ARCC_CFG_CNT_EN];
  assign adc_irq      = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_gain_write: assert property (@(posedge pclk) disable iff (!presetn)
    gain_wr && loaded_r && mode_r == ARCC_MODE_IDLE &&
    !(engine_evt.gcal_done && mode_r == ARCC_MODE_AUX_GCAL)
    |=> aux_gain == $past(pwdata[15:0]))
    else $error("gain write in idle not stored");

  a_factory_load: assert property (@(posedge pclk) disable iff (!presetn)
    !loaded_r |=> aux_gain == $past(factory_gain) ##1 loaded_r)
    else $error("factory gain not loaded after reset");

  a_gain_cal: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_r && engine_evt.gcal_done && mode_r == ARCC_MODE_AUX_GCAL
    |=> aux_gain == $past(engine_evt.gcal_value))
    else $error("calibrated gain not stored");

  a_gain_locked: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_r && gain_wr && mode_r != ARCC_MODE_IDLE &&
    !(engine_evt.gcal_done && mode_r == ARCC_MODE_AUX_GCAL)
    |=> $stable(aux_gain))
    else $error("gain written outside idle mode");

  a_limit_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ARCC_OFF_LIMIT |=> limit_r == $past(pwdata[15:0]))
    else $error("limit write lost");

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    engine_evt.conv_done && cnt_on && cnt_inc != limit_r && !clr_wr
    |=> cnt_r == $past(cnt_r) + 16'h0001 && !adc_irq)
    else $error("count did not step");

  a_count_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    engine_evt.conv_done && cnt_on && cnt_inc == limit_r
    |=> cnt_r == 16'h0000 && adc_irq)
    else $error("count did not wrap with interrupt");

  a_irq_cause: assert property (@(posedge pclk) disable iff (!presetn)
    adc_irq |-> $past(engine_evt.conv_done) &&
    (!$past(cnt_on) || $past(cnt_inc) == $past(limit_r)))
    else $error("interrupt without cause");

  a_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clr_wr |=> cnt_r == 16'h0000)
    else $error("reconfigure did not clear count");

  a_count_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == ARCC_OFF_COUNT
    |=> pready && prdata == {16'h0000, $past(cnt_r)})
    else $error("count read mismatch");

  a_count_off: assert property (@(posedge pclk) disable iff (!presetn)
    engine_evt.conv_done && !cnt_on && !clr_wr
    |=> adc_irq && $stable(cnt_r))
    else $error("disabled counting misbehaved");

  a_limit_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == ARCC_OFF_LIMIT) |=> $stable(limit_r))
    else $error("limit changed without a write");

  a_count_ro: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ARCC_OFF_COUNT && !engine_evt.conv_done
    |=> $stable(cnt_r))
    else $error("read-only count was written");

  a_count_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !engine_evt.conv_done && !clr_wr |=> $stable(cnt_r))
    else $error("count moved without a conversion");

  a_gain_hold: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_r && !gain_wr && !engine_evt.gcal_done |=> $stable(aux_gain))
    else $error("gain changed without a cause");

  a_cal_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_r && engine_evt.gcal_done && mode_r != ARCC_MODE_AUX_GCAL &&
    !gain_wr |=> $stable(aux_gain))
    else $error("calibration taken outside its mode");

  a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ARCC_OFF_MODE |=> adc_mode == $past(pwdata[2:0]))
    else $error("mode write lost");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_unmapped_rd: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr |-> prdata == 32'h00000000)
    else $error("unmapped access returned data");

endmodule

/* File: sim/tb_arcc_regs.sv */
`timescale 1ns/1ps
module tb_arcc_regs
  import arcc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [15:0] fgain, aux_gain, primary_ctrl;
  logic [2:0]  adc_mode;
  logic        count_en, adc_irq, err, e_irq;
  arcc_evt_t   evt;
  int          miscompares, n_tests, cyc, i;
  int          m_lim, m_cnt, m_gain, m_mode, m_en, m_pctrl;

  arcc_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .engine_evt(evt), .factory_gain(fgain), .aux_gain(aux_gain),
    .adc_mode(adc_mode), .primary_ctrl(primary_ctrl),
    .count_en(count_en), .adc_irq(adc_irq));

  always #2.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  task wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bound well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic mapped(input logic [31:0] a);
    return a inside {ARCC_OFF_AUX_GAIN, ARCC_OFF_LIMIT, ARCC_OFF_COUNT,
                     ARCC_OFF_MODE, ARCC_OFF_CONFIG, ARCC_OFF_PCTRL};
  endfunction

  // Request held until pready is seen; data taken in that same cycle
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      #1;
      if (pready === 1'b1) break;
      @(posedge pclk);
    end
    if (k == 50) miscompares++;
    rdat = prdata;
    err  = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(32'(err), 32'(!mapped(a)));
    case (a)
      ARCC_OFF_MODE: begin
        m_mode = d[2:0];
        m_cnt  = 0;
      end
      ARCC_OFF_PCTRL: begin
        m_cnt   = 0;
        m_pctrl = d[15:0];
      end
      ARCC_OFF_CONFIG: m_en = d[ARCC_CFG_CNT_EN];
      ARCC_OFF_LIMIT: m_lim = d[15:0];
      ARCC_OFF_AUX_GAIN: if (m_mode == ARCC_MODE_IDLE) m_gain = d[15:0];
      default: ;
    endcase
    // Outputs settle after the edge that stored the write
    #1;
    chk(32'(adc_mode), 32'(m_mode));
    chk(32'(count_en), 32'(m_en));
    chk(32'(primary_ctrl), 32'(m_pctrl));
    chk(32'(aux_gain), 32'(m_gain));
  endtask

  task rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(32'(err), 32'(!mapped(a)));
    chk(rdat, mapped(a) ? e : 32'h0);
  endtask

  task conv();
    @(posedge pclk);
    evt.conv_done <= 1'b1;
    @(posedge pclk);
    evt.conv_done <= 1'b0;
    e_irq = !m_en || (((m_cnt + 1) % 65536) == m_lim);
    if (m_en) m_cnt = e_irq ? 0 : m_cnt + 1;
    #1;
    chk(32'(adc_irq), 32'(e_irq));
    @(posedge pclk);
    #1;
    chk(32'(adc_irq), 32'h0);
  endtask

  task gcal(input logic [15:0] v);
    @(posedge pclk);
    evt.gcal_done  <= 1'b1;
    evt.gcal_value <= v;
    @(posedge pclk);
    evt.gcal_done  <= 1'b0;
    evt.gcal_value <= ~v;
    if (m_mode == ARCC_MODE_AUX_GCAL) m_gain = v;
    #1;
    chk(32'(aux_gain), 32'(m_gain));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(78033));
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; evt = '0; fgain = $urandom;
    m_lim = 1; m_cnt = 0; m_mode = 0; m_en = 0; m_gain = fgain; m_pctrl = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk(32'(aux_gain), 32'(fgain));
    rd(ARCC_OFF_AUX_GAIN, m_gain);
    rd(ARCC_OFF_LIMIT, 32'h1);
    rd(ARCC_OFF_COUNT, 32'h0);
    rd(32'hFFFF053C, 32'h0);
    $display("test 1 done");
    // Every mode code; only idle may accept the gain
    for (i = 0; i < 8; i++) begin
      wr(ARCC_OFF_MODE, i);
      // Software stays idle 23 us (4600 cycles) before a gain write
      if (i == ARCC_MODE_IDLE) repeat (4600) @(posedge pclk);
      wr(ARCC_OFF_AUX_GAIN, $urandom);
      rd(ARCC_OFF_AUX_GAIN, m_gain);
    end
    $display("test 2 done");
    wr(ARCC_OFF_MODE, 32'(ARCC_MODE_AUX_GCAL));
    repeat (2) gcal($urandom);
    wr(ARCC_OFF_MODE, 32'(ARCC_MODE_IDLE));
    gcal($urandom);
    rd(ARCC_OFF_AUX_GAIN, m_gain);
    $display("test 3 done");
    wr(ARCC_OFF_CONFIG, 32'h1);
    wr(ARCC_OFF_LIMIT, 32'h3);
    rd(ARCC_OFF_LIMIT, 32'h3);
    wr(ARCC_OFF_COUNT, 32'h00AA);
    for (i = 0; i < 7; i++) begin
      conv();
      rd(ARCC_OFF_COUNT, m_cnt);
    end
    wr(ARCC_OFF_LIMIT, 32'h1);
    repeat (2) conv();
    $display("test 4 done");
    wr(ARCC_OFF_LIMIT, 32'h0100);
    repeat (3) conv();
    wr(ARCC_OFF_PCTRL, $urandom);
    rd(ARCC_OFF_COUNT, m_cnt);
    repeat (2) conv();
    wr(ARCC_OFF_MODE, 32'(ARCC_MODE_IDLE));
    rd(ARCC_OFF_COUNT, m_cnt);
    $display("test 5 done");
    repeat (2) conv();
    wr(ARCC_OFF_CONFIG, 32'h0);
    repeat (3) begin
      conv();
      rd(ARCC_OFF_COUNT, m_cnt);
    end
    $display("test 6 done");
    wrap_up();
  end
endmodule
